// ==== src/touch_irq_calib.sv ====
`timescale 1ns/100ps
// Interrupt latch with spacing hold-off, baseline calibration and thresholds
// What this block does
// - Latch data interrupt on buffer-empty falling edge
// - Buffer access releases; rearm only after empty
// - Latch fault interrupt on zero-to-nonzero fault
// - Fault register clear releases fault interrupt
// - Enable low ignores sources; pin never latches
// - Normal spacing (period+5)*rate*4 ms
// - Low-power spacing ((period+5)/8+1)*8*rate*4 ms
// - Interrupt pin active low, open drain
// - Early event waits out spacing, else latches
// - First sample after reset becomes baseline
// - Touch judged from measurement minus baseline
// - Autocal recomputes baseline every clk*factor*64 ms
// - Skip periodic recalibration while touched
// - Stuck touch absorbed after timeout period
// - Stuck timeout zero disables absorption
// - Stuck field n gives factor n+1, readable
// - Threshold field n gives level n+1, readable
// - Out-of-range threshold write forces 00111111
// - Empty flag high when buffer holds nothing
// - Fault clear accepted only in stop modes
// - Fault codes 00 none, 01 ground, 10 supply
module touch_irq_calib #(
  parameter int MS_CYCLES = touch_irq_pkg::CYCLES_PER_MS  // Shorten in simulation
) (
  // Clocks and reset
  input  wire logic                    CLK,
  input  wire logic                    ARST_N,
  input  wire logic                    LINK_CLK,
  // Host register port
  input  wire touch_irq_pkg::reg_req_s REG_REQ,
  output logic [7:0]                   REG_RDATA,
  // Configuration and mode bits
  input  wire logic                    INTERRUPT_ENABLE_BIT,
  input  wire logic [3:0]              INTERRUPT_RATE_SETTING,
  input  wire logic [7:0]              SCAN_PERIOD_SETTING,
  input  wire logic                    LOW_POWER_RUN,
  input  wire logic                    RUN_MODE,
  input  wire logic                    AUTOCAL_ENABLE_BIT,
  input  wire logic [7:0]              MASTER_CLK_PERIOD,
  input  wire logic [7:0]              SAMPLE_PERIOD_FACTOR,
  // Buffer and fault status from the scan engine
  input  wire logic                    BUFFER_EMPTY_FLAG,
  input  wire logic [1:0]              FAULT_DETECTED,
  // Electrode samples on the link clock
  input  wire touch_irq_pkg::sample_s  LINK_SAMPLE,
  // Results
  output logic                         TOUCHED,
  output logic [15:0]                  BASELINE,
  output logic                         IRQ_N_O,
  output logic                         IRQ_N_OE
);

  // Register port decodes
  logic buf_access;   // Any touch buffer read or write
  logic fault_wr;     // Write to fault register
  assign buf_access = (REG_REQ.rd | REG_REQ.wr) && REG_REQ.addr == touch_irq_pkg::OFS_TOUCH_BUFFER;
  assign fault_wr   = REG_REQ.wr && REG_REQ.addr == touch_irq_pkg::OFS_FAULT;

  // Buffer-empty pin passes two flops before use
  logic [1:0] empty_sync;
  logic       empty_q;   // Previous synchronised level, for edge detection
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      empty_sync <= 2'b11;
      empty_q    <= 1'b1;
    end else begin
      empty_sync <= {empty_sync[0], BUFFER_EMPTY_FLAG};
      empty_q    <= empty_sync[1];
    end
  end

  // Fault code register: set wins over clear
  logic [1:0] fault_code;
  logic [1:0] fault_prev;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fault_code <= touch_irq_pkg::FAULT_NONE;
      fault_prev <= touch_irq_pkg::FAULT_NONE;
    end else begin
      fault_prev <= fault_code;
      if (fault_code == touch_irq_pkg::FAULT_NONE && FAULT_DETECTED != touch_irq_pkg::FAULT_NONE)
        fault_code <= FAULT_DETECTED;
      else if (fault_wr && !RUN_MODE)
        fault_code <= touch_irq_pkg::FAULT_NONE;
    end
  end

  // Source events
  logic data_event;
  logic fault_event;
  assign data_event  = empty_q && !empty_sync[1];
  assign fault_event = fault_prev == touch_irq_pkg::FAULT_NONE &&
                       fault_code != touch_irq_pkg::FAULT_NONE;

  // Spacing in ms, per mode
  logic [8:0]  base_sum;   // Nine bits so a period setting near 255 does not wrap
  logic [15:0] spacing_ms;
  always_comb begin
    base_sum = {1'b0, SCAN_PERIOD_SETTING} + 9'(touch_irq_pkg::SPACING_OFFSET);
    if (LOW_POWER_RUN)
      spacing_ms = 16'(({7'h00, base_sum} / 16'(touch_irq_pkg::LOWPWR_GRANULE) + 16'h0001)
                   * 16'(touch_irq_pkg::LOWPWR_GRANULE) * INTERRUPT_RATE_SETTING
                   * 16'(touch_irq_pkg::SPACING_FACTOR));
    else
      spacing_ms = 16'({7'h00, base_sum} * INTERRUPT_RATE_SETTING
                   * 16'(touch_irq_pkg::SPACING_FACTOR));
  end

  // Millisecond tick and hold-off counter, restarted on each latch
  logic [31:0] ms_div;
  logic [15:0] hold_ms;    // Milliseconds since the last latch
  logic        spaced;     // Spacing has elapsed
  logic        latch_now;
  assign spaced = hold_ms >= spacing_ms;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ms_div  <= 32'h00000000;
      hold_ms <= 16'hFFFF;
    end else if (latch_now) begin
      ms_div  <= 32'h00000000;
      hold_ms <= 16'h0000;
    end else if (ms_div == 32'(MS_CYCLES - 1)) begin
      ms_div  <= 32'h00000000;
      if (hold_ms != 16'hFFFF) hold_ms <= hold_ms + 16'h0001;
    end else begin
      ms_div <= ms_div + 32'h00000001;
    end
  end

  // Pending sources wait for the spacing; data arms only once the buffer empties
  logic data_pend, fault_pend, data_armed;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      data_pend  <= 1'b0;
      fault_pend <= 1'b0;
      data_armed <= 1'b1;
    end else if (!INTERRUPT_ENABLE_BIT) begin
      data_pend  <= 1'b0;
      fault_pend <= 1'b0;
      data_armed <= 1'b1;
    end else begin
      if (data_event && data_armed) begin
        data_pend  <= 1'b1;
        data_armed <= 1'b0;
      end else begin
        if (empty_sync[1]) data_armed <= 1'b1;
        if (latch_now || buf_access) data_pend <= 1'b0;
      end
      if (fault_event) fault_pend <= 1'b1;
      else if (latch_now) fault_pend <= 1'b0;
    end
  end

  assign latch_now = INTERRUPT_ENABLE_BIT && (data_pend || fault_pend) && spaced;

  // Latched interrupt sources
  logic irq_data, irq_fault;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_data  <= 1'b0;
      irq_fault <= 1'b0;
    end else if (!INTERRUPT_ENABLE_BIT) begin
      irq_data  <= 1'b0;
      irq_fault <= 1'b0;
    end else begin
      if (latch_now && data_pend) irq_data <= 1'b1;
      else if (buf_access) irq_data <= 1'b0;
      if (latch_now && fault_pend) irq_fault <= 1'b1;
      else if (fault_wr && !RUN_MODE) irq_fault <= 1'b0;
    end
  end

  // Open-drain pin: output low, enabled while asserted
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ_N_O  <= 1'b0;
      IRQ_N_OE <= 1'b0;
    end else begin
      IRQ_N_O  <= 1'b0;
      IRQ_N_OE <= irq_data | irq_fault;
    end
  end

  // Configuration registers
  logic [7:0] threshold_field;
  logic [7:0] stuck_field;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      threshold_field <= touch_irq_pkg::THRESHOLD_RESET;
      stuck_field     <= touch_irq_pkg::STUCK_RESET;
    end else if (REG_REQ.wr) begin
      if (REG_REQ.addr == touch_irq_pkg::OFS_TOUCH_THRESHOLD)
        threshold_field <= (REG_REQ.wdata > touch_irq_pkg::THRESHOLD_MAX) ?
                           touch_irq_pkg::THRESHOLD_MAX : REG_REQ.wdata;
      if (REG_REQ.addr == touch_irq_pkg::OFS_STUCK_KEY_TIMEOUT)
        stuck_field <= REG_REQ.wdata;
    end
  end

  // Read data; buffer contents live elsewhere, only status bits here
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_REQ.rd) begin
      unique case (REG_REQ.addr)
        touch_irq_pkg::OFS_TOUCH_BUFFER:      REG_RDATA <= {1'b0, empty_sync[1], 6'h00};
        touch_irq_pkg::OFS_FAULT:             REG_RDATA <= {6'h00, fault_code};
        touch_irq_pkg::OFS_TOUCH_THRESHOLD:   REG_RDATA <= threshold_field;
        touch_irq_pkg::OFS_STUCK_KEY_TIMEOUT: REG_RDATA <= stuck_field;
        default:                              REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Link-domain reset, released synchronously
  logic [1:0] link_rst;
  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) link_rst <= 2'b00;
    else         link_rst <= {link_rst[0], 1'b1};
  end

  // Samples cross into the main clock
  logic        samp_valid;
  logic [15:0] samp_cap;
  touch_sync_word #(.WIDTH(16)) u_sync (
    .src_clk   (LINK_CLK),
    .src_rst_n (link_rst[1]),
    .src_valid (LINK_SAMPLE.valid),
    .src_data  (LINK_SAMPLE.cap),
    .dst_clk   (CLK),
    .dst_rst_n (ARST_N),
    .dst_valid (samp_valid),
    .dst_data  (samp_cap)
  );

  // Touch decision: capacitance rises with touch
  logic [15:0] diff;
  logic        touch_now;
  assign diff      = (samp_cap > BASELINE) ? 16'(samp_cap - BASELINE) : 16'h0000;
  assign touch_now = diff > {8'h00, threshold_field} + 16'h0001;

  // Calibration periods in ms
  logic [31:0] cal_ms, stuck_ms;
  // Widen before multiplying so the product of two 8-bit settings is not cut
  assign cal_ms   = 32'(MASTER_CLK_PERIOD) * 32'(SAMPLE_PERIOD_FACTOR)
                    * 32'(touch_irq_pkg::CAL_FACTOR);
  assign stuck_ms = cal_ms * 32'({1'b0, stuck_field} + 9'h001);

  // Baseline, periodic and stuck-key calibration
  logic        have_base;
  logic [31:0] cal_cnt, stuck_cnt;
  logic        ms_tick;
  assign ms_tick = ms_div == 32'(MS_CYCLES - 1);
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      have_base <= 1'b0;
      BASELINE  <= 16'h0000;
      TOUCHED   <= 1'b0;
      cal_cnt   <= 32'h00000000;
      stuck_cnt <= 32'h00000000;
    end else begin
      if (samp_valid && !have_base) begin
        BASELINE  <= samp_cap;
        have_base <= 1'b1;
      end else if (samp_valid) begin
        TOUCHED <= touch_now;
      end
      if (ms_tick) begin
        cal_cnt <= cal_cnt + 32'h00000001;
        if (TOUCHED && stuck_field != 8'h00) stuck_cnt <= stuck_cnt + 32'h00000001;
      end
      if (!TOUCHED) stuck_cnt <= 32'h00000000;
      // Expired period waits for the next sample, so a sample is never missed
      if (AUTOCAL_ENABLE_BIT && have_base && cal_cnt >= cal_ms && samp_valid) begin
        cal_cnt <= 32'h00000000;
        if (!TOUCHED) BASELINE <= samp_cap;
      end
      if (have_base && stuck_field != 8'h00 && stuck_cnt >= stuck_ms && samp_valid) begin
        BASELINE  <= samp_cap;
        TOUCHED   <= 1'b0;
        stuck_cnt <= 32'h00000000;
      end
    end
  end

  // Assertions
  sequence data_src_s;
    INTERRUPT_ENABLE_BIT && latch_now && data_pend;
  endsequence

  pin_latch_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    data_src_s |=> ##1 IRQ_N_OE) else $error("pin not latched");
  enable_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !INTERRUPT_ENABLE_BIT |=> !irq_data && !irq_fault) else $error("latched while off");
  spacing_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    latch_now |-> spaced) else $error("spacing violated");
  counter_restart_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    latch_now |=> hold_ms == 16'h0000) else $error("hold-off not restarted");
  buf_release_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    buf_access && !(latch_now && data_pend) |=> !irq_data) else $error("no release");
  fault_run_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    RUN_MODE && fault_code != 2'h0 |=> fault_code != 2'h0) else $error("cleared in run");
  thresh_clip_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    threshold_field <= touch_irq_pkg::THRESHOLD_MAX) else $error("threshold out of range");
  pin_drive_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    IRQ_N_O == 1'b0) else $error("pin drives high");

endmodule

// ==== src/touch_irq_pkg.sv ====
// Package: register offsets, field codes, timing constants and carriers
package touch_irq_pkg;

  // Register offsets on the host register port
  localparam logic [3:0] OFS_TOUCH_BUFFER      = 4'h0;
  localparam logic [3:0] OFS_FAULT             = 4'h1;
  localparam logic [3:0] OFS_TOUCH_THRESHOLD   = 4'h4;
  localparam logic [3:0] OFS_STUCK_KEY_TIMEOUT = 4'h9;

  // Values after reset and the threshold limit
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  localparam logic [7:0] STUCK_RESET     = 8'h00;
  localparam logic [7:0] THRESHOLD_MAX   = 8'h3F;

  // Fault codes
  localparam logic [1:0] FAULT_NONE  = 2'h0;
  localparam logic [1:0] FAULT_SHORT_GND = 2'h1;
  localparam logic [1:0] FAULT_SHORT_SUP = 2'h2;

  // Spacing and calibration formula constants
  localparam int SPACING_OFFSET  = 5;
  localparam int SPACING_FACTOR  = 4;
  localparam int LOWPWR_GRANULE  = 8;
  localparam int CAL_FACTOR      = 64;

  // One millisecond at 125 MHz (8 ns period)
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

  // Host register access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // One sample of the electrode measurement, in the link domain
  typedef struct packed {
    logic        valid;
    logic [15:0] cap;
  } sample_s;

endpackage

// ==== src/touch_sync_word.sv ====
`timescale 1ns/100ps
// Word crossing by toggle handshake from the link domain to the main clock
module touch_sync_word #(
  parameter int WIDTH = 16
) (
  // Source side
  input  wire logic             src_clk,
  input  wire logic             src_rst_n,
  input  wire logic             src_valid,
  input  wire logic [WIDTH-1:0] src_data,
  // Destination side
  input  wire logic             dst_clk,
  input  wire logic             dst_rst_n,
  output logic                  dst_valid,
  output logic [WIDTH-1:0]      dst_data
);

  logic             src_tog;   // Flips once per captured word
  logic [WIDTH-1:0] src_hold;  // Held stable while the toggle crosses
  logic             s1, s2, s3; // s1 is read only by s2

  // Capture the word and flip the toggle in the source domain
  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      src_tog  <= 1'b0;
      src_hold <= '0;
    end else if (src_valid) begin
      src_tog  <= ~src_tog;
      src_hold <= src_data;
    end
  end

  // Two-flop synchroniser plus edge stage
  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= src_tog;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Hold data is stable for many destination cycles; samples must be spaced out
  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      dst_valid <= 1'b0;
      dst_data  <= '0;
    end else begin
      dst_valid <= s2 ^ s3;
      if (s2 ^ s3) begin
        dst_data <= src_hold;
      end
    end
  end

endmodule

// ==== test/touch_sample_src.sv ====
// Scan engine model that hands electrode samples to the block on the link clock
`timescale 1ns/100ps
module touch_sample_src (
  // Link clock from the scan engine
  input  wire logic            link_clk,
  // Sample toward the block
  output touch_irq_pkg::sample_s smp
);
  // Idle pattern until the first sample
  initial smp = '{valid: 1'b0, cap: 16'h5A5A};

  // One valid pulse, then a quiet gap of at least 8 link cycles
  task automatic send(input logic [15:0] v);
    @(posedge link_clk);
    #1 smp = '{valid: 1'b1, cap: v};
    @(posedge link_clk);
    // Stale value is not left visible, so a late capture shows up as wrong
    #1 smp = '{valid: 1'b0, cap: ~v};
    repeat (8) @(posedge link_clk);
  endtask
endmodule

// ==== test/test_touch_irq_calib.sv ====
// Self-checking bench for the interrupt, calibration and threshold block
`timescale 1ns/100ps
module test_touch_irq_calib;
  localparam int MS    = 10;        // Shortened millisecond in cycles
  localparam int SPACE = 20 * MS;   // (0+5)*1*4 ms at rate 1
  localparam int CAL   = 64 * MS;   // 1*1*64 ms recalibration period
  logic                    clk, link_clk, arst_n;  // Clocks and reset
  touch_irq_pkg::reg_req_s req;                    // Register request
  logic [7:0]              rdata;                  // Register read data
  logic                    en, lp, run, acal, empty;
  logic [1:0]              fault;
  logic [3:0]              rate;
  logic [7:0]              scan, master_clk_period, sample_period_factor;
  touch_irq_pkg::sample_s  smp;
  logic                    touched, irq_o, irq_oe;
  logic [15:0]             base_o, base;
  wire                     pin = irq_oe ? irq_o : 1'b1;  // Board pull-up
  int                      n_errors, samples_checked;
  logic [15:0]             exp_q[$];                     // Expected read data
  logic                    rd_d;                          // Read taken last edge

  touch_irq_calib #(.MS_CYCLES(MS)) uut (
    .CLK(clk), .ARST_N(arst_n), .LINK_CLK(link_clk), .REG_REQ(req), .REG_RDATA(rdata),
    .INTERRUPT_ENABLE_BIT(en), .INTERRUPT_RATE_SETTING(rate), .SCAN_PERIOD_SETTING(scan),
    .LOW_POWER_RUN(lp), .RUN_MODE(run), .AUTOCAL_ENABLE_BIT(acal),
    .MASTER_CLK_PERIOD(master_clk_period), .SAMPLE_PERIOD_FACTOR(sample_period_factor), .BUFFER_EMPTY_FLAG(empty),
    .FAULT_DETECTED(fault), .LINK_SAMPLE(smp), .TOUCHED(touched), .BASELINE(base_o),
    .IRQ_N_O(irq_o), .IRQ_N_OE(irq_oe));
  touch_sample_src src (.link_clk(link_clk), .smp(smp));

  // Clocks: link clock runs at 48 ns with an unrelated phase
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One-cycle register pulses, launched on the falling edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({8'h00, e});
    @(negedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk);
    req <= '0;
  endtask

  // Read data is settled the cycle after the read is taken
  always @(posedge clk) rd_d <= req.rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1)
      check("REG_RDATA", {8'h00, rdata}, exp_q.pop_front());
  end

  // Bounded wait for a pin level, then compare
  task automatic wait_pin(input logic lvl, input int lim, input string what);
    for (int i = 0; i < lim && pin !== lvl; i++) @(negedge clk);
    check(what, {15'h0, pin}, {15'h0, lvl});
  endtask
  // Pin must keep one level for a whole span
  task automatic hold_pin(input logic lvl, input int n, input string what);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge clk);
      if (pin !== lvl) ok = 1'b0;
    end
    check(what, {15'h0, ok}, 16'h1);
  endtask
  // Sample crosses two domains, so allow it time to land
  task automatic feed(input logic [15:0] v);
    src.send(v);
    repeat (20) @(negedge clk);
  endtask

  // Watchdog far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    logic [7:0] v;
    req = '0; arst_n = 1'b0; en = 1'b0; lp = 1'b0; run = 1'b1; acal = 1'b0;
    empty = 1'b1; fault = touch_irq_pkg::FAULT_NONE; rate = 4'h1; scan = 8'h00;
    master_clk_period = 8'h01; sample_period_factor = 8'h01;
    void'($urandom(32'h4b4e5c82));
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    // Register reset values, readback and clamping
    rd(touch_irq_pkg::OFS_TOUCH_THRESHOLD, touch_irq_pkg::THRESHOLD_RESET);
    rd(touch_irq_pkg::OFS_STUCK_KEY_TIMEOUT, touch_irq_pkg::STUCK_RESET);
    rd(4'hC, 8'h00);
    rd(touch_irq_pkg::OFS_TOUCH_BUFFER, 8'h40);
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom_range(0, 63));
      wr(touch_irq_pkg::OFS_TOUCH_THRESHOLD, v);
      rd(touch_irq_pkg::OFS_TOUCH_THRESHOLD, v);
    end
    wr(touch_irq_pkg::OFS_TOUCH_THRESHOLD, 8'h40);
    rd(touch_irq_pkg::OFS_TOUCH_THRESHOLD, touch_irq_pkg::THRESHOLD_MAX);
    wr(touch_irq_pkg::OFS_STUCK_KEY_TIMEOUT, 8'hFF);
    rd(touch_irq_pkg::OFS_STUCK_KEY_TIMEOUT, 8'hFF);
    wr(touch_irq_pkg::OFS_STUCK_KEY_TIMEOUT, 8'h00);
    $display("test registers done");
    // Baseline, touch boundary at level 64, recalibration
    base = 16'($urandom_range(16'h1000, 16'h7000));
    feed(base);
    check("BASELINE", base_o, base);
    feed(base + 16'h0040);
    check("TOUCHED", {15'h0, touched}, 16'h0);
    feed(base + 16'h0041);
    check("TOUCHED", {15'h0, touched}, 16'h1);
    acal = 1'b1;
    repeat (CAL + 50) @(negedge clk);
    feed(base + 16'h0041);
    check("BASELINE", base_o, base);
    check("TOUCHED", {15'h0, touched}, 16'h1);
    feed(base + 16'h0005);
    check("TOUCHED", {15'h0, touched}, 16'h0);
    repeat (CAL + 50) @(negedge clk);
    feed(base + 16'h0005);
    check("BASELINE", base_o, base + 16'h0005);
    // Stuck touch with factor 2 is absorbed after 128 ms
    wr(touch_irq_pkg::OFS_STUCK_KEY_TIMEOUT, 8'h01);
    feed(base + 16'h0050);
    check("TOUCHED", {15'h0, touched}, 16'h1);
    repeat (2 * CAL + 100) @(negedge clk);
    feed(base + 16'h0050);
    check("BASELINE", base_o, base + 16'h0050);
    check("TOUCHED", {15'h0, touched}, 16'h0);
    wr(touch_irq_pkg::OFS_STUCK_KEY_TIMEOUT, 8'h00);
    $display("test calibration done");
    // Data interrupt, release, spacing hold-off, fault
    en = 1'b1;
    empty = 1'b0;
    wait_pin(1'b0, 8, "pin data");
    check("IRQ_N_O", {15'h0, irq_o}, 16'h0);
    wr(touch_irq_pkg::OFS_TOUCH_BUFFER, 8'h00);
    wait_pin(1'b1, 4, "pin buffer release");
    fault = touch_irq_pkg::FAULT_SHORT_GND;
    hold_pin(1'b1, SPACE - 40, "pin held off");
    wait_pin(1'b0, 60, "pin fault");
    rd(touch_irq_pkg::OFS_FAULT, {6'h00, touch_irq_pkg::FAULT_SHORT_GND});
    wr(touch_irq_pkg::OFS_FAULT, 8'h00);
    hold_pin(1'b0, 10, "pin run clear");
    fault = touch_irq_pkg::FAULT_NONE;
    run = 1'b0;
    wr(touch_irq_pkg::OFS_FAULT, 8'h00);
    wait_pin(1'b1, 4, "pin fault release");
    hold_pin(1'b1, SPACE + 20, "pin no rearm");
    rd(touch_irq_pkg::OFS_FAULT, {6'h00, touch_irq_pkg::FAULT_NONE});
    empty = 1'b1;
    repeat (5) @(negedge clk);
    empty = 1'b0;
    wait_pin(1'b0, 8, "pin rearm");
    $display("test interrupt done");
    // Enable low ignores both sources
    en = 1'b0;
    wait_pin(1'b1, 4, "pin disabled");
    empty = 1'b1;
    repeat (5) @(negedge clk);
    empty = 1'b0;
    fault = touch_irq_pkg::FAULT_SHORT_SUP;
    hold_pin(1'b1, SPACE + 20, "pin never latch");
    rd(touch_irq_pkg::OFS_FAULT, {6'h00, touch_irq_pkg::FAULT_SHORT_SUP});
    $display("test enable done");
    print_verdict();
  end
endmodule
